// File: asf_map.svh
// register offsets, field positions and reset values of the status flag block
`ifndef ASF_MAP_SVH
`define ASF_MAP_SVH

// register addresses
`define ASF_ADDR_W 6
`define ASF_STATUS_ADDR 6'h01
`define ASF_MODE_ADDR 6'h02

// register width and reset values
`define ASF_REG_W 16
`define ASF_STATUS_RESET 16'h0540
`define ASF_MODE_RESET 16'h0510

// status field positions
`define ASF_ST_LOCK 15
`define ASF_ST_RESYNC 14
`define ASF_ST_REGMAP 13
`define ASF_ST_CRCERR 12
`define ASF_ST_CRCTYPE 11
`define ASF_ST_RESET 10
`define ASF_ST_WLEN_HI 9
`define ASF_ST_WLEN_LO 8
`define ASF_ST_FUSE 7
`define ASF_ST_HIGHSIDE 6
`define ASF_ST_CH0_READY 0

// mode field positions
`define ASF_MD_REGCRC 13
`define ASF_MD_RXCRC 12
`define ASF_MD_CRCTYPE 11
`define ASF_MD_RESET 10
`define ASF_MD_WLEN_HI 9
`define ASF_MD_WLEN_LO 8
`define ASF_MD_TIMEOUT 4
`define ASF_MD_DRDYHIZ 1
`define ASF_MD_DRDYFMT 0

// flag reset values
`define ASF_RESET_FLAG_INIT 1'b1
`define ASF_HIGHSIDE_INIT 1'b1

`endif

// File: asf_pkg.sv
// types shared by the status flag block
package asf_pkg;

   // commands handed over by the serial frame decoder
   typedef enum logic [2:0] {
      ASF_CMD_POLL = 3'b000,
      ASF_CMD_RDREG = 3'b001,
      ASF_CMD_WRREG = 3'b010,
      ASF_CMD_LOCK = 3'b011,
      ASF_CMD_UNLOCK = 3'b100,
      ASF_CMD_RESET = 3'b101
   } asf_cmd_type;

   // word length codes
   typedef enum logic [1:0] {
      ASF_WL_16 = 2'b00,
      ASF_WL_24 = 2'b01,
      ASF_WL_32_ZERO = 2'b10,
      ASF_WL_32_SIGN = 2'b11
   } asf_wlen_type;

endpackage

// File: asf_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/10ps
module asf_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // level in and out
   input wire logic async_i,
   input wire logic init_i,
   output logic sync_o
);

   logic meta_ff;
   logic sync_ff;

   // first stage feeds only the second stage; both reset to the caller's idle level
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         meta_ff <= init_i;
         sync_ff <= init_i;
      end else if (ce_i) begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   // synchronised level out
   assign sync_o = sync_ff;

endmodule

// File: asf_flag.sv
// sticky flag cell, a set in the same cycle as a clear wins
`timescale 1ns/10ps
module asf_flag #(
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // set and clear
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   logic flag_ff;
   logic nxt_flag;

   // set beats clear so no event is lost
   always_comb begin
      nxt_flag = flag_ff;
      if (clr_i) begin
         nxt_flag = 1'b0;
      end
      if (set_i) begin
         nxt_flag = 1'b1;
      end
   end

   // flag storage
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         flag_ff <= INIT;
      end else if (ce_i) begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_o = flag_ff;

endmodule

// File: asf_status_regs.sv
// status flags and mode register of the isolated converter
`timescale 1ns/10ps
`include "asf_map.svh"
module asf_status_regs
   import asf_pkg::*;
(
   // clock, reset and clock enable
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // commands from the serial frame decoder
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_code_i,
   input wire logic [`ASF_ADDR_W-1:0] cmd_addr_i,
   input wire logic [`ASF_REG_W-1:0] cmd_wdata_i,
   // read answer
   output logic rd_valid_o,
   output logic [`ASF_REG_W-1:0] rd_data_o,
   // on-chip events, same clock
   input wire logic resync_event_i,
   input wire logic regmap_crc_fault_i,
   input wire logic input_crc_error_i,
   input wire logic fuse_parity_fault_i,
   input wire logic chan0_new_data_i,
   input wire logic chan0_data_read_i,
   // faults from the isolated side, asynchronous levels
   input wire logic high_side_supply_fault_i,
   input wire logic isolation_link_error_i,
   // mode settings to the converter
   output logic reg_crc_en_o,
   output logic rx_crc_en_o,
   output logic crc_type_o,
   output logic [1:0] word_length_code_o,
   output logic timeout_en_o,
   output logic ready_pin_hiz_o,
   output logic ready_pin_pulse_o,
   // status flags to the converter
   output logic lock_flag_o,
   output logic resync_flag_o,
   output logic channel0_data_ready_flag_o
);

   // decoded command strobes
   logic cmd_poll;
   logic cmd_read;
   logic cmd_write;
   logic cmd_lock;
   logic cmd_unlock;
   logic cmd_reset;
   logic status_read;
   logic mode_write;

   // register state
   logic [`ASF_REG_W-1:0] mode_ff;
   logic [`ASF_REG_W-1:0] nxt_mode;
   logic lock_ff;
   logic [`ASF_REG_W-1:0] rd_data_ff;
   logic rd_valid_ff;

   // flags
   logic resync_flag;
   logic regmap_flag;
   logic crcerr_flag;
   logic reset_flag;
   logic fuse_flag;
   logic high_side_fault_flag;
   logic channel0_data_ready_flag;

   // synchronised isolated-side faults
   logic hs_supply_sync;
   logic hs_link_sync;
   logic [`ASF_REG_W-1:0] status_word;

   // true when a command of the given kind is presented
   function automatic logic is_cmd(input logic v, input logic [2:0] c, input asf_cmd_type k);
      is_cmd = v && (c == k);
   endfunction

   // command decode
   assign cmd_poll = is_cmd(cmd_valid_i, cmd_code_i, ASF_CMD_POLL);
   assign cmd_read = is_cmd(cmd_valid_i, cmd_code_i, ASF_CMD_RDREG);
   assign cmd_write = is_cmd(cmd_valid_i, cmd_code_i, ASF_CMD_WRREG);
   assign cmd_lock = is_cmd(cmd_valid_i, cmd_code_i, ASF_CMD_LOCK);
   assign cmd_unlock = is_cmd(cmd_valid_i, cmd_code_i, ASF_CMD_UNLOCK);
   assign cmd_reset = is_cmd(cmd_valid_i, cmd_code_i, ASF_CMD_RESET);

   // either way of reading status counts as a read
   assign status_read = cmd_poll || (cmd_read && (cmd_addr_i == `ASF_STATUS_ADDR));
   // writes only reach the mode address; status writes fall through
   assign mode_write = cmd_write && (cmd_addr_i == `ASF_MODE_ADDR);

   // isolated-side faults pass two flip-flops first
   asf_sync u_sync_supply (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .async_i(high_side_supply_fault_i),
      .init_i(1'b0),
      .sync_o(hs_supply_sync)
   );

   asf_sync u_sync_link (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .async_i(isolation_link_error_i),
      .init_i(1'b0),
      .sync_o(hs_link_sync)
   );

   // next mode value: a write stores all bits, reset command restores defaults
   always_comb begin
      nxt_mode = mode_ff;
      if (cmd_reset) begin
         nxt_mode = `ASF_MODE_RESET;
      end else if (mode_write) begin
         nxt_mode = cmd_wdata_i;
      end
   end

   // mode register
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         mode_ff <= `ASF_MODE_RESET;
      end else if (ce_i) begin
         mode_ff <= nxt_mode;
      end
   end

   // interface lock indicator
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         lock_ff <= 1'b0;
      end else if (ce_i) begin
         if (cmd_lock) begin
            lock_ff <= 1'b1;
         end else if (cmd_unlock || cmd_reset) begin
            lock_ff <= 1'b0;
         end
      end
   end

   // resynchronisation flag
   asf_flag #(.INIT(1'b0)) u_resync (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .set_i(resync_event_i),
      .clr_i(status_read || cmd_reset),
      .flag_o(resync_flag)
   );

   // register map CRC fault flag
   asf_flag #(.INIT(1'b0)) u_regmap (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .set_i(regmap_crc_fault_i),
      .clr_i(status_read || cmd_reset),
      .flag_o(regmap_flag)
   );

   // input CRC error flag
   asf_flag #(.INIT(1'b0)) u_crcerr (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .set_i(input_crc_error_i),
      .clr_i(status_read || cmd_reset),
      .flag_o(crcerr_flag)
   );

   // reset-occurred flag, cleared only by a mode write with the reset field at zero
   asf_flag #(.INIT(`ASF_RESET_FLAG_INIT)) u_reset (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .set_i(cmd_reset),
      .clr_i(mode_write && !cmd_wdata_i[`ASF_MD_RESET]),
      .flag_o(reset_flag)
   );

   // fuse fault flag; a persisting fault keeps setting it after a read
   asf_flag #(.INIT(1'b0)) u_fuse (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .set_i(fuse_parity_fault_i),
      .clr_i(status_read || cmd_reset),
      .flag_o(fuse_flag)
   );

   // high-side supply or isolation link fault flag
   asf_flag #(.INIT(`ASF_HIGHSIDE_INIT)) u_high_side (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .set_i(hs_supply_sync || hs_link_sync || cmd_reset),
      .clr_i(status_read),
      .flag_o(high_side_fault_flag)
   );

   // channel-0 data ready, dropped when the data are fetched
   asf_flag #(.INIT(1'b0)) u_channel0_data_ready_flag (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .set_i(chan0_new_data_i),
      .clr_i(chan0_data_read_i || cmd_reset),
      .flag_o(channel0_data_ready_flag)
   );

   // status word; reserved bits 5:1 read zero
   always_comb begin
      status_word = '0;
      status_word[`ASF_ST_LOCK] = lock_ff;
      status_word[`ASF_ST_RESYNC] = resync_flag;
      status_word[`ASF_ST_REGMAP] = regmap_flag;
      status_word[`ASF_ST_CRCERR] = crcerr_flag;
      status_word[`ASF_ST_CRCTYPE] = mode_ff[`ASF_MD_CRCTYPE];
      status_word[`ASF_ST_RESET] = reset_flag;
      status_word[`ASF_ST_WLEN_HI] = mode_ff[`ASF_MD_WLEN_HI];
      status_word[`ASF_ST_WLEN_LO] = mode_ff[`ASF_MD_WLEN_LO];
      status_word[`ASF_ST_FUSE] = fuse_flag;
      status_word[`ASF_ST_HIGHSIDE] = high_side_fault_flag;
      status_word[`ASF_ST_CH0_READY] = channel0_data_ready_flag;
   end

   // read answer, registered; value is the one before any clear
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rd_data_ff <= `ASF_STATUS_RESET;
         rd_valid_ff <= 1'b0;
      end else if (ce_i) begin
         rd_valid_ff <= cmd_poll || cmd_read;
         if (status_read) begin
            rd_data_ff <= status_word;
         end else if (cmd_read && (cmd_addr_i == `ASF_MODE_ADDR)) begin
            // mode reset field mirrors the reset-occurred flag
            rd_data_ff <= {mode_ff[15:11], reset_flag, mode_ff[9:0]};
         end else if (cmd_read) begin
            rd_data_ff <= '0;
         end
      end
   end

   // outputs
   assign rd_valid_o = rd_valid_ff;
   assign rd_data_o = rd_data_ff;
   assign reg_crc_en_o = mode_ff[`ASF_MD_REGCRC];
   assign rx_crc_en_o = mode_ff[`ASF_MD_RXCRC];
   assign crc_type_o = mode_ff[`ASF_MD_CRCTYPE];
   assign word_length_code_o = mode_ff[`ASF_MD_WLEN_HI:`ASF_MD_WLEN_LO];
   assign timeout_en_o = mode_ff[`ASF_MD_TIMEOUT];
   assign ready_pin_hiz_o = mode_ff[`ASF_MD_DRDYHIZ];
   assign ready_pin_pulse_o = mode_ff[`ASF_MD_DRDYFMT];
   assign lock_flag_o = lock_ff;
   assign resync_flag_o = resync_flag;
   assign channel0_data_ready_flag_o = channel0_data_ready_flag;

endmodule

// File: asf_status_regs_sva.sv
// port checker of the status flag block
`timescale 1ns/10ps
`include "asf_map.svh"
module asf_status_regs_chk
   import asf_pkg::*;
(
   // clock and control
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   // command port
   input wire logic cmd_valid_i,
   input wire logic [2:0] cmd_code_i,
   input wire logic [`ASF_ADDR_W-1:0] cmd_addr_i,
   input wire logic [`ASF_REG_W-1:0] cmd_wdata_i,
   input wire logic rd_valid_o,
   input wire logic [`ASF_REG_W-1:0] rd_data_o,
   // events and flags
   input wire logic resync_event_i,
   input wire logic reg_crc_en_o,
   input wire logic crc_type_o,
   input wire logic [1:0] word_length_code_o,
   input wire logic lock_flag_o,
   input wire logic resync_flag_o,
   input wire logic channel0_data_ready_flag_o
);
   logic take;
   logic st_rd_ff;
   logic [`ASF_REG_W-1:0] wd_ff;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // command accepted at this edge
   assign take = cmd_valid_i && ce_i;
   // marks an answer that belongs to a status read
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_rd_ff <= 1'b0;
      end else if (ce_i) begin
         st_rd_ff <= take && (cmd_code_i == ASF_CMD_POLL
            || (cmd_code_i == ASF_CMD_RDREG && cmd_addr_i == `ASF_STATUS_ADDR));
      end
   end
   // write data port of the previous cycle, for the mode outputs
   always_ff @(posedge clk_i) begin
      wd_ff <= cmd_wdata_i;
   end
   property p_lock;
      take && cmd_code_i == ASF_CMD_LOCK |=> lock_flag_o;
   endproperty
   a_lock: assert property (p_lock) else $error("lock flag not set");
   property p_unlock;
      take && cmd_code_i == ASF_CMD_UNLOCK |=> !lock_flag_o;
   endproperty
   a_unlock: assert property (p_unlock) else $error("lock flag not cleared");
   property p_resync;
      resync_event_i && ce_i |=> resync_flag_o;
   endproperty
   a_resync: assert property (p_resync) else $error("resync flag not set");
   property p_rdclr;
      take && cmd_code_i == ASF_CMD_POLL && !resync_event_i |=> !resync_flag_o;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("resync flag kept after poll");
   property p_answer;
      take && (cmd_code_i == ASF_CMD_POLL || cmd_code_i == ASF_CMD_RDREG) |=> rd_valid_o;
   endproperty
   a_answer: assert property (p_answer) else $error("no read answer");
   property p_mirror;
      rd_valid_o && st_rd_ff |-> rd_data_o[11] == crc_type_o
         && rd_data_o[9:8] == word_length_code_o && rd_data_o[5:1] == 5'h00;
   endproperty
   a_mirror: assert property (p_mirror) else $error("status mode fields wrong");
   property p_snap;
      rd_valid_o && st_rd_ff |-> rd_data_o[15] == $past(lock_flag_o)
         && rd_data_o[14] == $past(resync_flag_o)
         && rd_data_o[0] == $past(channel0_data_ready_flag_o);
   endproperty
   a_snap: assert property (p_snap) else $error("status flags wrong");
   property p_mode;
      take && cmd_code_i == ASF_CMD_WRREG && cmd_addr_i == `ASF_MODE_ADDR |=>
         reg_crc_en_o == wd_ff[13] && crc_type_o == wd_ff[11]
         && word_length_code_o == wd_ff[9:8];
   endproperty
   a_mode: assert property (p_mode) else $error("mode outputs wrong");
   property p_rst;
      $rose(rstn_i) |-> rd_data_o == `ASF_STATUS_RESET && word_length_code_o == 2'h1
         && !lock_flag_o && !crc_type_o && !reg_crc_en_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   c_lock: cover property (take && cmd_code_i == ASF_CMD_LOCK);
   c_stat: cover property (rd_valid_o && st_rd_ff);
   c_wr: cover property (take && cmd_code_i == ASF_CMD_WRREG);
endmodule

bind asf_status_regs asf_status_regs_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
   .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_addr_i(cmd_addr_i),
   .cmd_wdata_i(cmd_wdata_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
   .resync_event_i(resync_event_i), .reg_crc_en_o(reg_crc_en_o), .crc_type_o(crc_type_o),
   .word_length_code_o(word_length_code_o), .lock_flag_o(lock_flag_o),
   .resync_flag_o(resync_flag_o), .channel0_data_ready_flag_o(channel0_data_ready_flag_o));

// File: asf_host.sv
// host model driving the command port
`timescale 1ns/10ps
module asf_host (
   // clock
   input wire logic clk_i,
   // read answer
   input wire logic rd_valid_i,
   input wire logic [15:0] rd_data_i,
   // command port
   output logic cmd_valid_o,
   output logic [2:0] cmd_code_o,
   output logic [5:0] cmd_addr_o,
   output logic [15:0] cmd_wdata_o
);
   // idle port at time zero
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 3'h0;
      cmd_addr_o = 6'h00;
      cmd_wdata_o = 16'h0000;
   end
   // one command held over its taking edge, answer sampled while it stands
   task send(input logic [2:0] code, input logic [5:0] addr, input logic [15:0] data,
      output logic v, output logic [15:0] d);
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_code_o = code;
      cmd_addr_o = addr;
      cmd_wdata_o = data;
      @(negedge clk_i);
      v = rd_valid_i;
      d = rd_data_i;
      cmd_valid_o = 1'b0;
      // released lines turn over so stale values never look valid
      cmd_addr_o = ~cmd_addr_o;
      cmd_wdata_o = ~cmd_wdata_o;
   endtask
endmodule

// File: adc_status_flag_register_bench.sv
// self-checking bench for the status flag block
`timescale 1ns/10ps
`include "asf_map.svh"
module adc_status_flag_register_bench import asf_pkg::*;;
   logic clk_i, rstn_i, ce_i, cmd_valid, rd_valid;
   logic [2:0] cmd_code;
   logic [5:0] cmd_addr;
   logic [15:0] cmd_wdata, rd_data, wd;
   logic ev_rs, ev_rm, ev_ce, ev_fu, ev_nd, ev_dr, hs_sup, hs_iso;
   logic crc_en, rx_en, crc_t, tmo, hiz, pls, lock, rs_fl, drdy;
   logic [1:0] wlen, w;
   int err_count, n_compared, cycles;
   asf_status_regs dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid),
      .cmd_code_i(cmd_code), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
      .rd_valid_o(rd_valid), .rd_data_o(rd_data), .resync_event_i(ev_rs),
      .regmap_crc_fault_i(ev_rm), .input_crc_error_i(ev_ce), .fuse_parity_fault_i(ev_fu),
      .chan0_new_data_i(ev_nd), .chan0_data_read_i(ev_dr), .high_side_supply_fault_i(hs_sup),
      .isolation_link_error_i(hs_iso), .reg_crc_en_o(crc_en), .rx_crc_en_o(rx_en),
      .crc_type_o(crc_t), .word_length_code_o(wlen), .timeout_en_o(tmo),
      .ready_pin_hiz_o(hiz), .ready_pin_pulse_o(pls), .lock_flag_o(lock),
      .resync_flag_o(rs_fl), .channel0_data_ready_flag_o(drdy));
   asf_host host (.clk_i(clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_addr_o(cmd_addr),
      .cmd_wdata_o(cmd_wdata));
   // word comparison
   task check16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // flag comparison
   task check1(input logic got, input logic exp);
      check16({15'h0000, got}, {15'h0000, exp});
   endtask
   // counts, verdict and end of run
   task summarize;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // command without answer
   task cmd(input logic [2:0] code, input logic [5:0] addr, input logic [15:0] data);
      logic v;
      logic [15:0] d;
      host.send(code, addr, data, v, d);
      check1(v, 1'b0);
   endtask
   // poll or register read with expected word
   task rd(input logic [2:0] code, input logic [5:0] addr, input logic [15:0] exp);
      logic v;
      logic [15:0] d;
      host.send(code, addr, 16'h0000, v, d);
      check1(v, 1'b1);
      check16(d, exp);
   endtask
   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // hang guard
   initial begin
      cycles = 0;
      forever begin
         @(posedge clk_i);
         cycles++;
         if (cycles == 3000) begin
            err_count++;
            summarize();
         end
      end
   end
   // main sequence
   initial begin
      {rstn_i, ev_rs, ev_rm, ev_ce, ev_fu, ev_nd, ev_dr, hs_sup, hs_iso} = 9'h000;
      ce_i = 1'b1;
      err_count = 0;
      n_compared = 0;
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1;
      check1(tmo, 1'b1);
      rd(ASF_CMD_RDREG, `ASF_STATUS_ADDR, 16'h0540);
      rd(ASF_CMD_RDREG, `ASF_MODE_ADDR, 16'h0510);
      rd(ASF_CMD_RDREG, 6'h3F, 16'h0000);
      rd(ASF_CMD_POLL, 6'h00, 16'h0500);
      for (int i = 0; i < 4; i++) begin
         w = 2'(i);
         wd = {4'h3, w[0], 1'b0, w, 3'h0, w[0], 2'h0, w};
         cmd(ASF_CMD_WRREG, `ASF_MODE_ADDR, wd);
         check16({8'h00, crc_en, rx_en, crc_t, wlen, tmo, hiz, pls},
            {8'h00, 2'h3, w[0], w, w[0], w});
         rd(ASF_CMD_RDREG, `ASF_STATUS_ADDR, {4'h0, w[0], 1'b0, w, 8'h00});
         rd(ASF_CMD_RDREG, `ASF_MODE_ADDR, wd);
      end
      @(negedge clk_i);
      {ev_rs, ev_rm, ev_ce, ev_fu, ev_nd} = 5'h1F;
      @(negedge clk_i);
      {ev_rs, ev_rm, ev_ce, ev_fu, ev_nd} = 5'h00;
      check1(rs_fl, 1'b1);
      check1(drdy, 1'b1);
      rd(ASF_CMD_RDREG, `ASF_STATUS_ADDR, 16'h7B81);
      rd(ASF_CMD_POLL, 6'h00, 16'h0B01);
      @(negedge clk_i);
      ev_dr = 1'b1;
      @(negedge clk_i);
      ev_dr = 1'b0;
      ev_fu = 1'b1;
      rd(ASF_CMD_POLL, 6'h00, 16'h0B80);
      rd(ASF_CMD_POLL, 6'h00, 16'h0B80);
      ev_fu = 1'b0;
      rd(ASF_CMD_POLL, 6'h00, 16'h0B80);
      rd(ASF_CMD_POLL, 6'h00, 16'h0B00);
      for (int k = 0; k < 2; k++) begin
         {hs_sup, hs_iso} = k[0] ? 2'h2 : 2'h1;
         repeat (3) @(negedge clk_i);
         {hs_sup, hs_iso} = 2'h0;
         repeat (4) @(negedge clk_i);
         rd(ASF_CMD_RDREG, `ASF_STATUS_ADDR, 16'h0B40);
         rd(ASF_CMD_POLL, 6'h00, 16'h0B00);
      end
      cmd(ASF_CMD_LOCK, 6'h00, 16'h0000);
      check1(lock, 1'b1);
      rd(ASF_CMD_POLL, 6'h00, 16'h8B00);
      cmd(ASF_CMD_UNLOCK, 6'h00, 16'h0000);
      check1(lock, 1'b0);
      cmd(ASF_CMD_WRREG, `ASF_STATUS_ADDR, 16'hFFFF);
      rd(ASF_CMD_RDREG, `ASF_STATUS_ADDR, 16'h0B00);
      @(negedge clk_i);
      ce_i = 1'b0;
      cmd(ASF_CMD_LOCK, 6'h00, 16'h0000);
      ce_i = 1'b1;
      check1(lock, 1'b0);
      cmd(ASF_CMD_RESET, 6'h00, 16'h0000);
      rd(ASF_CMD_RDREG, `ASF_STATUS_ADDR, 16'h0540);
      rd(ASF_CMD_RDREG, `ASF_MODE_ADDR, 16'h0510);
      cmd(ASF_CMD_WRREG, `ASF_MODE_ADDR, 16'h0000);
      rd(ASF_CMD_POLL, 6'h00, 16'h0000);
      rstn_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rstn_i = 1'b1;
      rd(ASF_CMD_RDREG, `ASF_STATUS_ADDR, 16'h0540);
      summarize();
   end
endmodule
